// [hdl/slcd_pkg.sv]
// Package of constants and types shared by the segment LCD driver files
package slcd_pkg;

	// ------------------------------------------------------------
	// Memory map of the data RAM window
	// ------------------------------------------------------------
	localparam logic [7:0] SLCD_BP_ADDR = 8'h04; // Bank pointer location
	localparam logic [7:0] SLCD_DISP_LO = 8'h40; // First display address
	localparam logic [7:0] SLCD_DISP_HI = 8'h60; // Last display address
	localparam logic [7:0] SLCD_BP_RST = 8'h00; // Bank pointer after reset
	localparam logic [7:0] SLCD_BP_DISPLAY = 8'h01; // Value that selects display memory
	localparam int SLCD_DEPTH = 33; // Bytes in the window, 40H..60H

	// ------------------------------------------------------------
	// Panel geometry and scan clock
	// ------------------------------------------------------------
	localparam int SLCD_NUM_SEG = 33; // Segment driver outputs
	localparam int SLCD_SHARED_SEG = 32; // Segment output that becomes the fourth common
	localparam int SLCD_NUM_COM = 3; // Dedicated common outputs
	localparam logic [2:0] SLCD_DIV_MAX_SEL = 3'h6; // Select 6 means divide by 2^8
	localparam logic [15:0] SLCD_DIV_BASE = 16'h0004; // Divide by 2^2 at select 0

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	// Multiplex arrangement: 2, 3 or 4 commons
	typedef enum logic [1:0] {SLCD_DUTY_2, SLCD_DUTY_3, SLCD_DUTY_4} slcd_duty_t;

	// Pin level: VSS, lower step, upper step (half VLCD at 1/2 bias), VLCD
	typedef enum logic [1:0] {SLCD_LV_VSS, SLCD_LV_LOW, SLCD_LV_HIGH, SLCD_LV_VLCD} slcd_level_t;

	// Scan sequencer states
	typedef enum logic [1:0] {SLCD_ST_IDLE, SLCD_ST_SCAN, SLCD_ST_BLANK} slcd_state_t;

	// Configuration options, static during operation
	typedef struct packed {
		slcd_duty_t duty; // Multiplex arrangement
		logic bias_third; // 1: 1/3 bias, 0: 1/2 bias
		logic [2:0] div_sel; // Scan clock divide select, 0..6
		logic halt_display_on; // 1: keep scanning in halt
		logic low_group_logic; // Segments 0..7 as logic outputs
		logic [7:0] seg_logic_mask; // Segments 8..15 as logic outputs, one bit each
	} slcd_cfg_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr; // Data RAM address
		logic [7:0] wdata; // Write data
		logic wr; // Write strobe
		logic rd; // Read strobe
	} slcd_bus_t;

endpackage : slcd_pkg

// [hdl/slcd_clkdiv.sv]
// Scan clock divider: one tick per 2^(sel+2) source clock ticks
`timescale 1ns/1ps
`default_nettype none
module slcd_clkdiv
	import slcd_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic src_tick_i,
	input wire logic [2:0] div_sel_i,
	output logic tick_o
);

	// ------------------------------------------------------------
	// Counter and terminal mask
	// ------------------------------------------------------------
	logic [7:0] cnt_reg; // Source tick count
	logic [2:0] sel_w; // Clamped select
	logic [7:0] mask_w; // Low bits that must all be one
	logic term_w; // Terminal count reached on a source tick

	// Out-of-range selects fall back to the slowest rate
	assign sel_w = (div_sel_i > SLCD_DIV_MAX_SEL) ? SLCD_DIV_MAX_SEL : div_sel_i;
	assign mask_w = 8'((SLCD_DIV_BASE << sel_w) - 16'h0001);
	assign term_w = src_tick_i && ((cnt_reg & mask_w) == mask_w);

	// Free running count; the mask picks the power of two
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cnt_reg <= 8'h00;
			tick_o <= 1'b0;
		end else begin
			cnt_reg <= src_tick_i ? cnt_reg + 8'h01 : cnt_reg;
			tick_o <= term_w;
		end
	end

	// Smallest division is four, so ticks are at least four cycles apart
	AST_TICK_SPACING: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		tick_o |=> !tick_o [*3])
		else $error("scan ticks closer than four cycles");

endmodule : slcd_clkdiv
`default_nettype wire

// [hdl/slcd_seg_cell.sv]
// One segment output: LCD waveform level or static logic level
`timescale 1ns/1ps
`default_nettype none
module slcd_seg_cell
	import slcd_pkg::*;
(
	input wire logic pixel_on_i,
	input wire logic pol_i,
	input wire logic bias_third_i,
	input wire logic blank_i,
	input wire logic logic_mode_i,
	input wire logic logic_bit_i,
	output var slcd_level_t level_o
);

	// ------------------------------------------------------------
	// Level selection
	// ------------------------------------------------------------
	always_comb begin
		if (blank_i) begin
			// Non-lighting level
			level_o = SLCD_LV_VSS;
		end else if (logic_mode_i) begin
			level_o = logic_bit_i ? SLCD_LV_VLCD : SLCD_LV_VSS;
		end else if (pixel_on_i) begin
			// Opposite extreme of the selected common lights it
			level_o = pol_i ? SLCD_LV_VLCD : SLCD_LV_VSS;
		end else if (bias_third_i) begin
			level_o = pol_i ? SLCD_LV_LOW : SLCD_LV_HIGH;
		end else begin
			// At 1/2 bias an off segment follows the selected common
			level_o = pol_i ? SLCD_LV_VSS : SLCD_LV_VLCD;
		end
	end

endmodule : slcd_seg_cell
`default_nettype wire

// [hdl/slcd_driver.sv]
// Segment LCD driver: banked display memory, scan sequencer and pin levels
//
// Functional notes
// - Display memory at 40H..60H, bank pointer at 04H
// - Bank pointer one: writes reach display memory
// - Bank pointer otherwise: window is general data memory
// - Scan runs continuously without software help
// - Stored one lights segment, zero darkens
// - Duty 1/2, 1/3 or 1/4 by option
// - Waveforms for 1/2 or 1/3 bias
// - At 1/2 duty third common stays idle
// - Logic output pin shows bit zero statically
// - Segments 0..7 grouped, 8..15 individually optioned
// - Scan clock is source over 2^2..2^8
// - Four-common mode turns shared pin into common
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module slcd_driver
	import slcd_pkg::*;
#(
	parameter int NUM_SEG = SLCD_NUM_SEG // Segment outputs
)
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire slcd_bus_t bus_i,
	output logic [7:0] rdata_o,
	input wire slcd_cfg_t cfg_i,
	input wire logic src_tick_i,
	input wire logic halt_i,
	output var slcd_level_t [SLCD_NUM_COM-1:0] com_level_o,
	output var slcd_level_t [NUM_SEG-1:0] seg_level_o
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] bank_pointer_reg; // Bank pointer
	logic [7:0] disp_mem_reg [SLCD_DEPTH]; // Display memory, bit k for common k
	logic [7:0] gen_mem_reg [SLCD_DEPTH]; // General data behind the same window
	slcd_state_t st_reg; // Scan sequencer state
	logic [1:0] com_idx_reg; // Common being selected
	logic pol_reg; // Half of the slot, swaps drive polarity

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	logic in_window_w; // Address inside 40H..60H
	logic [7:0] offs_w; // Offset into the window
	logic [5:0] idx_w; // Storage index
	logic disp_sel_w; // Window maps to display memory
	logic bp_hit_w; // Address is the bank pointer
	logic [7:0] disp_at_idx_w; // Display byte at the addressed index

	assign in_window_w = (bus_i.addr >= SLCD_DISP_LO) && (bus_i.addr <= SLCD_DISP_HI);
	assign offs_w = bus_i.addr - SLCD_DISP_LO;
	assign idx_w = in_window_w ? offs_w[5:0] : 6'h00;
	assign disp_sel_w = (bank_pointer_reg == SLCD_BP_DISPLAY);
	assign bp_hit_w = (bus_i.addr == SLCD_BP_ADDR);
	assign disp_at_idx_w = disp_mem_reg[idx_w];

	// Read mux; unmapped addresses read as zero
	logic [7:0] rd_mux_w;
	assign rd_mux_w = bp_hit_w ? bank_pointer_reg :
		!in_window_w ? 8'h00 :
		disp_sel_w ? disp_at_idx_w : gen_mem_reg[idx_w];

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
			bank_pointer_reg <= SLCD_BP_RST;
		end else begin
			rdata_o <= bus_i.rd ? rd_mux_w : 8'h00;
			if (bus_i.wr && bp_hit_w) begin
				bank_pointer_reg <= bus_i.wdata;
			end
		end
	end

	// Window storage; the bank pointer picks which array a write lands in.
	// Contents are not cleared by reset, like ordinary RAM, so reset
	// cost stays low; the outputs are dark during reset anyway.
	generate
		for (genvar g = 0; g < SLCD_DEPTH; g++) begin : g_mem
			always_ff @(posedge clk_sys_i) begin
				if (bus_i.wr && in_window_w && idx_w == 6'(g)) begin
					if (disp_sel_w) begin
						disp_mem_reg[g] <= bus_i.wdata;
					end else begin
						gen_mem_reg[g] <= bus_i.wdata;
					end
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Scan clock
	// ------------------------------------------------------------
	logic tick_w; // One scan step

	slcd_clkdiv u_clkdiv (
		.clk_sys_i (clk_sys_i),
		.rst_n_i (rst_n_i),
		.src_tick_i (src_tick_i),
		.div_sel_i (cfg_i.div_sel),
		.tick_o (tick_w)
	);

	// ------------------------------------------------------------
	// Scan sequencer
	// ------------------------------------------------------------
	logic [1:0] last_com_w; // Highest common index for the duty
	logic halt_dark_w; // Halt with the display switched off
	logic blank_w; // Outputs held at the dark level
	slcd_state_t st_next; // Next sequencer state

	always_comb begin
		unique case (cfg_i.duty)
			SLCD_DUTY_2: last_com_w = 2'h1;
			SLCD_DUTY_3: last_com_w = 2'h2;
			SLCD_DUTY_4: last_com_w = 2'h3;
			default: last_com_w = 2'h3; // Unused code scans four common slots; the shared pin stays a segment
		endcase
	end

	assign halt_dark_w = halt_i && !cfg_i.halt_display_on;
	assign blank_w = (st_reg != SLCD_ST_SCAN);

	// Idle until the first scan step after reset, then scan or blank
	always_comb begin
		st_next = st_reg;
		unique case (st_reg)
			SLCD_ST_IDLE: begin
				if (tick_w) begin
					st_next = halt_dark_w ? SLCD_ST_BLANK : SLCD_ST_SCAN;
				end
			end
			SLCD_ST_SCAN: begin
				if (halt_dark_w) begin
					st_next = SLCD_ST_BLANK;
				end
			end
			SLCD_ST_BLANK: begin
				if (!halt_dark_w) begin
					st_next = SLCD_ST_SCAN;
				end
			end
			default: st_next = SLCD_ST_IDLE;
		endcase
	end

	// Each common slot has two halves of opposite polarity so the glass
	// never sees a net DC level
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			st_reg <= SLCD_ST_IDLE;
			com_idx_reg <= 2'h0;
			pol_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			if (tick_w) begin
				pol_reg <= !pol_reg;
				if (pol_reg) begin
					com_idx_reg <= (com_idx_reg >= last_com_w) ? 2'h0 : com_idx_reg + 2'h1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Common levels
	// ------------------------------------------------------------
	slcd_level_t com_sel_lv_w; // Level of the selected common
	slcd_level_t com_idle_lv_w; // Level of an unselected common
	slcd_level_t [SLCD_NUM_COM-1:0] com_next; // Next common pin levels

	assign com_sel_lv_w = pol_reg ? SLCD_LV_VSS : SLCD_LV_VLCD;
	assign com_idle_lv_w = !cfg_i.bias_third ? SLCD_LV_HIGH :
		(pol_reg ? SLCD_LV_HIGH : SLCD_LV_LOW);

	generate
		for (genvar c = 0; c < SLCD_NUM_COM; c++) begin : g_com
			assign com_next[c] = blank_w ? SLCD_LV_VSS :
				(2'(c) > last_com_w) ? SLCD_LV_VSS :
				(com_idx_reg == 2'(c)) ? com_sel_lv_w : com_idle_lv_w;
		end
	endgenerate

	// ------------------------------------------------------------
	// Segment levels
	// ------------------------------------------------------------
	slcd_level_t [NUM_SEG-1:0] seg_cell_w; // Cell outputs
	slcd_level_t [NUM_SEG-1:0] seg_next; // Next segment pin levels
	logic shared_com_w; // Shared pin acts as the fourth common
	logic [NUM_SEG-1:0] logic_mode_w; // Pins optioned as logic outputs

	assign shared_com_w = (cfg_i.duty == SLCD_DUTY_4);

	generate
		for (genvar s = 0; s < NUM_SEG; s++) begin : g_seg
			if (s < 8) begin : g_grp
				assign logic_mode_w[s] = cfg_i.low_group_logic;
			end else if (s < 16) begin : g_bit
				assign logic_mode_w[s] = cfg_i.seg_logic_mask[s-8];
			end else begin : g_lcd
				assign logic_mode_w[s] = 1'b0;
			end

			slcd_seg_cell u_cell (
				.pixel_on_i (disp_mem_reg[s][com_idx_reg]),
				.pol_i (pol_reg),
				.bias_third_i (cfg_i.bias_third),
				.blank_i (blank_w),
				.logic_mode_i (logic_mode_w[s]),
				.logic_bit_i (disp_mem_reg[s][0]),
				.level_o (seg_cell_w[s])
			);

			if (s == SLCD_SHARED_SEG) begin : g_shared
				assign seg_next[s] = !shared_com_w ? seg_cell_w[s] :
					blank_w ? SLCD_LV_VSS :
					(com_idx_reg == 2'h3) ? com_sel_lv_w : com_idle_lv_w;
			end else begin : g_plain
				assign seg_next[s] = seg_cell_w[s];
			end
		end
	endgenerate

	// Every pin level leaves through a flip-flop
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			com_level_o <= {SLCD_NUM_COM{SLCD_LV_VSS}};
			seg_level_o <= {NUM_SEG{SLCD_LV_VSS}};
		end else begin
			com_level_o <= com_next;
			seg_level_o <= seg_next;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	AST_BP_READ: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(bus_i.rd && bp_hit_w) |=> (rdata_o == $past(bank_pointer_reg)))
		else $error("bank pointer read returned wrong value");

	AST_DISP_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(bus_i.wr && in_window_w && disp_sel_w) |=>
		(disp_mem_reg[$past(idx_w)] == $past(bus_i.wdata)))
		else $error("display write did not reach display memory");

	AST_GEN_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(bus_i.wr && in_window_w && !disp_sel_w && !$past(bus_i.wr)) |=>
		$stable(disp_mem_reg[0]) && (rdata_o == 8'h00))
		else $error("general write disturbed display memory");

	AST_SCAN_STEP: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(tick_w && pol_reg && com_idx_reg == last_com_w) |=> (com_idx_reg == 2'h0 && !pol_reg))
		else $error("scan did not wrap after the last common");

	AST_SEG_ON: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!blank_w && !logic_mode_w[20] && disp_mem_reg[20][com_idx_reg]) |=>
		(seg_level_o[20] == ($past(pol_reg) ? SLCD_LV_VLCD : SLCD_LV_VSS)))
		else $error("lit segment not at opposite extreme");

	AST_DUTY3_RANGE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(cfg_i.duty == SLCD_DUTY_3 && tick_w && pol_reg && com_idx_reg >= 2'h2) |=>
		(com_idx_reg == 2'h0))
		else $error("common index beyond duty");

	AST_HALF_BIAS: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!cfg_i.bias_third && st_reg == SLCD_ST_SCAN) |=> (com_level_o[0] != SLCD_LV_LOW))
		else $error("third level used under half bias");

	AST_DUTY2_COMMON_LINE_TWO: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(cfg_i.duty == SLCD_DUTY_2) |=> (com_level_o[2] == SLCD_LV_VSS))
		else $error("third common driven at half duty");

	AST_LOGIC_OUT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!blank_w && cfg_i.seg_logic_mask[2]) |=>
		(seg_level_o[10] == ($past(disp_mem_reg[10][0]) ? SLCD_LV_VLCD : SLCD_LV_VSS)))
		else $error("logic output does not show bit zero");

	AST_GROUP_OPT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		logic_mode_w[7:0] == {8{cfg_i.low_group_logic}})
		else $error("low segment group not optioned together");

	AST_SHARED_COM: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(shared_com_w && !blank_w && com_idx_reg == 2'h3) |=>
		(seg_level_o[SLCD_SHARED_SEG] == ($past(pol_reg) ? SLCD_LV_VSS : SLCD_LV_VLCD)))
		else $error("shared pin not driving fourth common");

	AST_RESET_DARK: assert property (@(posedge clk_sys_i)
		!rst_n_i |=> (com_level_o == {SLCD_NUM_COM{SLCD_LV_VSS}}) && (st_reg == SLCD_ST_IDLE))
		else $error("outputs not dark after reset");

	AST_HALT_DARK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(halt_dark_w && st_reg != SLCD_ST_IDLE) |=> ##1 (seg_level_o[20] == SLCD_LV_VSS))
		else $error("display not dark in halt");

	COV_FOUR_COM: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		shared_com_w && com_idx_reg == 2'h3 && st_reg == SLCD_ST_SCAN);

	COV_DISP_WRITE: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		bus_i.wr && in_window_w && disp_sel_w);

	COV_HALT_BLANK: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		st_reg == SLCD_ST_SCAN ##1 st_reg == SLCD_ST_BLANK);

endmodule : slcd_driver
`default_nettype wire

// [testbench/slcd_panel_model.sv]
// Passive multiplexed glass model: records which pixels saw full drive
`timescale 1ns/1ps
`default_nettype none
module slcd_panel_model
	import slcd_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic clear_i,
	input wire slcd_duty_t duty_i,
	input wire slcd_level_t [SLCD_NUM_COM-1:0] com_level_i,
	input wire slcd_level_t [SLCD_NUM_SEG-1:0] seg_level_i,
	output logic [3:0][SLCD_NUM_SEG-1:0] lit_o,
	output logic low_seen_o,
	output logic common_line_two_moved_o
);
	// ------------------------------------------------------------
	// Pixel detection
	// ------------------------------------------------------------
	// Only a full VLCD swing darkens a pixel; partial swings leave it clear
	function automatic logic full_swing(input slcd_level_t a, input slcd_level_t b);
		return (a == SLCD_LV_VSS && b == SLCD_LV_VLCD) || (a == SLCD_LV_VLCD && b == SLCD_LV_VSS);
	endfunction : full_swing

	// Sticky records, cleared by the bench between configurations
	always @(posedge clk_sys_i) begin : glass
		int ncom;
		slcd_level_t cl;
		ncom = (duty_i == SLCD_DUTY_2) ? 2 : (duty_i == SLCD_DUTY_3) ? 3 : 4;
		if (clear_i) begin
			lit_o <= '0;
			low_seen_o <= 1'b0;
			common_line_two_moved_o <= 1'b0;
		end else begin
			// Glass only wires up as many commons as the duty uses
			for (int k = 0; k < ncom; k++) begin
				cl = (k == 3) ? seg_level_i[SLCD_SHARED_SEG] : com_level_i[k];
				for (int n = 0; n < ((ncom == 4) ? 32 : 33); n++) begin
					if (full_swing(cl, seg_level_i[n])) lit_o[k][n] <= 1'b1;
				end
			end
			if (com_level_i[2] != SLCD_LV_VSS) common_line_two_moved_o <= 1'b1;
			for (int n = 0; n < SLCD_NUM_SEG; n++) begin
				if (seg_level_i[n] == SLCD_LV_LOW) low_seen_o <= 1'b1;
			end
			if (com_level_i[0] == SLCD_LV_LOW) low_seen_o <= 1'b1;
		end
	end
endmodule : slcd_panel_model
`default_nettype wire

// [testbench/tb.sv]
// Self-checking testbench for the segment LCD driver
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk((g), (e))
module tb;
	import slcd_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observation
	// ------------------------------------------------------------
	typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} slcd_row_t;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	slcd_bus_t bus = '0;
	slcd_cfg_t cfg = '{SLCD_DUTY_3, 1'b1, 3'h0, 1'b1, 1'b0, 8'h00};
	logic src_tick_i = 1'b0;
	logic halt_i = 1'b0;
	logic clear = 1'b1; // Glass record reset
	logic [7:0] rdata;
	logic [7:0] v;
	logic [7:0] p;
	logic lg;
	slcd_level_t [SLCD_NUM_COM-1:0] com_lv;
	slcd_level_t [SLCD_NUM_SEG-1:0] seg_lv, s1;
	logic [3:0][SLCD_NUM_SEG-1:0] lit, exp_lit;
	logic low_seen, common_line_two_moved;
	int err_count = 0;
	int checks = 0;
	int cyc = 0; // Timeout counter
	int src_div = 1; // Source tick spacing in cycles
	int src_ph = 0;
	int n_cyc;
	// Ordinary traffic: optional write, then read-back
	slcd_row_t rows [10] = '{
		'{1'b1, 8'h04, 8'h01, 8'h01}, // Display bank
		'{1'b1, 8'h40, 8'ha5, 8'ha5},
		'{1'b1, 8'h04, 8'h00, 8'h00}, // General bank
		'{1'b1, 8'h40, 8'h5a, 8'h5a},
		'{1'b1, 8'h04, 8'h02, 8'h02}, // Not exactly one: still general
		'{1'b0, 8'h40, 8'h00, 8'h5a},
		'{1'b1, 8'h04, 8'h01, 8'h01},
		'{1'b0, 8'h40, 8'h00, 8'ha5}, // Display byte kept apart
		'{1'b1, 8'h61, 8'h77, 8'h00}, // Outside the window
		'{1'b1, 8'h3f, 8'h11, 8'h00}
	};

	slcd_driver slcd_driver_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus),
		.rdata_o(rdata), .cfg_i(cfg), .src_tick_i(src_tick_i), .halt_i(halt_i),
		.com_level_o(com_lv), .seg_level_o(seg_lv));
	slcd_panel_model slcd_panel_model_i (.clk_sys_i(clk_sys_i), .clear_i(clear),
		.duty_i(cfg.duty), .com_level_i(com_lv), .seg_level_i(seg_lv), .lit_o(lit),
		.low_seen_o(low_seen), .common_line_two_moved_o(common_line_two_moved));

	initial begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end

	// Source tick pulse train and hang guard
	always @(posedge clk_sys_i) begin
		src_ph <= (src_ph + 1 >= src_div) ? 0 : src_ph + 1;
		src_tick_i <= (src_ph == 0);
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			final_report();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [159:0] got, input logic [159:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	// Display bytes are reached only through the addressed window
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys_i);
		bus <= '0;
		@(posedge clk_sys_i);
	endtask : bus_wr

	// Data stands only in the cycle after the strobe, so sample there
	task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys_i);
		bus <= '0;
		@(posedge clk_sys_i);
		d = rdata;
	endtask : bus_rd

	// Cycles until common zero next changes level
	task automatic wait_change();
		slcd_level_t prev;
		prev = com_lv[0];
		n_cyc = 0;
		do begin
			@(posedge clk_sys_i);
			n_cyc++;
		end while (com_lv[0] === prev && n_cyc < 1100);
	endtask : wait_change

	function automatic logic [7:0] pat(input int n);
		return 8'(n * 8'h25 + 8'h0b);
	endfunction : pat

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_sys_i);
		`CHK({com_lv, seg_lv}, 0);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		`CHK({com_lv, seg_lv}, 0);
		foreach (rows[i]) begin
			if (rows[i].w) bus_wr(rows[i].a, rows[i].d);
			bus_rd(rows[i].a, v);
			`CHK(v, rows[i].e);
		end
		for (int n = 0; n < 33; n++) bus_wr(8'(8'h40 + n), pat(n));
		// Every duty against both biases, judged by the glass
		for (int d = 0; d < 3; d++) begin
			for (int b = 0; b < 2; b++) begin
				cfg.duty <= slcd_duty_t'(d);
				cfg.bias_third <= b[0];
				clear <= 1'b1;
				repeat (12) @(posedge clk_sys_i);
				clear <= 1'b0;
				repeat (120) @(posedge clk_sys_i);
				for (int n = 0; n < 33; n++) begin
					p = pat(n);
					for (int k = 0; k < 4; k++) exp_lit[k][n] = (k < d + 2 && n < ((d == 2) ? 32 : 33)) ? p[k] : 1'b0;
				end
				`CHK(lit, exp_lit);
				`CHK(low_seen, b);
				`CHK(common_line_two_moved, d != 0);
			end
		end
		// Low group plus segments 8 and 10 as logic pins; 9 and 11..16 keep scanning
		cfg <= '{SLCD_DUTY_3, 1'b1, 3'h0, 1'b1, 1'b1, 8'h05};
		repeat (12) @(posedge clk_sys_i);
		s1 = seg_lv;
		repeat (4) @(posedge clk_sys_i);
		for (int n = 0; n < 17; n++) begin
			p = pat(n);
			lg = n < 8 || n == 8 || n == 10;
			if (lg) `CHK({s1[n], seg_lv[n]}, p[0] ? 4'hf : 4'h0);
			else `CHK(s1[n] != seg_lv[n], 1'b1);
		end
		// Divider ratios, select 1 repeated with a slower source tick, then select 7
		cfg.low_group_logic <= 1'b0;
		cfg.seg_logic_mask <= 8'h00;
		// Select 7 is out of range and must run at the slowest rate
		for (int s = 0; s < 9; s++) begin
			cfg.div_sel <= (s == 7) ? 3'h1 : (s == 8) ? 3'h7 : 3'(s);
			src_div <= (s == 7) ? 3 : 1;
			repeat (3) wait_change();
			`CHK(n_cyc, ((s == 7) ? 24 : (4 << ((s == 8) ? 6 : s))));
		end
		// Halt with display off, then on
		cfg.div_sel <= 3'h0;
		src_div <= 1;
		cfg.halt_display_on <= 1'b0;
		halt_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		n_cyc = 0;
		repeat (40) begin
			@(posedge clk_sys_i);
			if ({com_lv, seg_lv} !== '0) n_cyc++;
		end
		`CHK(n_cyc, 0);
		cfg.halt_display_on <= 1'b1;
		repeat (3) wait_change();
		`CHK(n_cyc, 4);
		halt_i <= 1'b0;
		// Mid-run reset darkens the pins and clears the bank pointer
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		`CHK({com_lv, seg_lv}, 0);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		bus_rd(8'h04, v);
		`CHK(v, 8'h00);
		final_report();
	end
endmodule : tb
`default_nettype wire
